// ===== logic/cbr_pkg.sv
`default_nettype none
package cbr_pkg;
   localparam logic [7:0] CMD_READ = 8'h06;
   localparam logic [7:0] RSP_READ = 8'h07;
   localparam logic [7:0] CMD_WRITE = 8'h08;
   localparam logic [7:0] RSP_WRITE = 8'h09;
   localparam int ID_BYTES = 8;
   localparam int BLK_BYTES = 16;
   localparam logic [7:0] SVC_MIN = 8'h01;
   localparam logic [7:0] RD_SVC_MAX = 8'h0F;
   localparam logic [7:0] WR_SVC_MAX = 8'h0B;
   localparam logic [7:0] WR_SVC_SPLIT = 8'h08;
   localparam logic [7:0] BLK_MIN = 8'h01;
   localparam logic [7:0] RD_BLK_MAX_RF = 8'h0D;
   localparam logic [7:0] RD_BLK_MAX = 8'h0F;
   localparam logic [7:0] WR_BLK_MAX_LO = 8'h0C;
   localparam logic [7:0] WR_BLK_MAX_HI = 8'h0B;
   localparam logic [7:0] ST1_OK = 8'h00;
   localparam logic [7:0] ST1_ERR = 8'hFF;
   localparam logic [7:0] ST2_OK = 8'h00;
   localparam logic [7:0] ST2_HOST_SILENT = 8'h50;
   localparam logic [7:0] ST2_HOST_ERR = 8'h51;
   localparam logic [7:0] ST2_SVC_CNT = 8'hA1;
   localparam logic [7:0] ST2_BLK_CNT = 8'hA2;
   localparam logic [7:0] ST2_SVC_DIFF = 8'hA3;
   localparam int BL_SHORT_BIT = 7;
   localparam logic [7:0] BL_SHORT_HDR = 8'h80;
   localparam logic [7:0] SVC_FILL_HI = 8'h09;
   localparam logic [7:0] SVC_FILL_LO = 8'h00;
   localparam logic [8:0] RSP_IDX_ST1 = 9'h009;
   localparam logic [8:0] RSP_IDX_ST2 = 9'h00A;
   localparam logic [8:0] RSP_IDX_M = 9'h00B;
   localparam logic [8:0] RSP_BASE_LEN = 9'h00B;
   localparam logic [8:0] CMD_IDX_K = 9'h009;
   localparam int CLK_MHZ = 40;
   localparam int HOST_WAIT_US = 1000;
   localparam int HOST_WAIT_CYC = HOST_WAIT_US * CLK_MHZ;
   localparam int RSP_WAIT_US = 2000;
   localparam int RSP_WAIT_CYC = RSP_WAIT_US * CLK_MHZ;

   function automatic logic [7:0] id_byte(input logic [63:0] id, input logic [3:0] i);
      return id[63 - 8 * i -: 8];
   endfunction : id_byte
endpackage : cbr_pkg
`default_nettype wire

// ===== logic/cbr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cbr_link_if;
   logic cmd_valid;
   logic cmd_ready;
   logic [7:0] cmd_data;
   logic cmd_last;
   logic rsp_valid;
   logic rsp_ready;
   logic [7:0] rsp_data;
   logic rsp_last;
   modport tag (input cmd_valid, input cmd_data, input cmd_last, output cmd_ready,
                output rsp_valid, output rsp_data, output rsp_last, input rsp_ready);
   modport reader (output cmd_valid, output cmd_data, output cmd_last, input cmd_ready,
                   input rsp_valid, input rsp_data, input rsp_last, output rsp_ready);
endinterface : cbr_link_if
`default_nettype wire

// ===== logic/cbr_tag.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_tag #(
   parameter int HOST_WAIT = cbr_pkg::HOST_WAIT_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   cbr_link_if.tag link,
   input wire logic [63:0] own_id,
   input wire logic rf_mode,
   input wire logic tunnel_mode,
   output logic host_rd_req,
   output logic [7:0] host_blk,
   input wire logic host_rd_valid,
   input wire logic [7:0] host_rd_data,
   input wire logic host_err,
   input wire logic host_ack,
   output logic host_wr_valid,
   input wire logic host_wr_ready,
   output logic [7:0] host_wr_data,
   output logic host_wr_last
);
   typedef enum logic [2:0] {S_CMD, S_EVAL, S_MWR, S_TWR, S_TWAIT, S_TRD, S_RSP} cbr_dst_t;
   typedef enum logic [2:0] {P_CODE, P_ID, P_K, P_SVC, P_M, P_BL, P_DATA, P_END} cbr_ph_t;
   typedef struct packed {
      cbr_dst_t st;
      cbr_ph_t ph;
      logic [8:0] cnt;
      logic [7:0] code;
      logic id_ok;
      logic comp;
      logic [7:0] k;
      logic [7:0] m;
      logic [15:0] svc0;
      logic svc_diff;
      logic [1:0] ebyte;
      logic [1:0] elen;
      logic [3:0] bi;
      logic [0:14][7:0] blk;
      logic [0:239][7:0] dbuf;
      logic [0:255][7:0] mem;
      logic err;
      logic [7:0] st2;
      logic [8:0] ridx;
      logic [7:0] hidx;
      logic [7:0] hdat;
      logic hreq;
      logic [15:0] tmo;
      logic [0:1][8:0] fifo;
      logic [1:0] fcnt;
      logic frd;
      logic fwr;
   } cbr_tag_st_t;

   cbr_tag_st_t s_ff;
   cbr_tag_st_t nxt_s;

   function automatic logic [7:0] blk_max(input logic wr, input logic [7:0] k, input logic rf);
      if (wr)
      begin
         return (k > cbr_pkg::WR_SVC_SPLIT) ? cbr_pkg::WR_BLK_MAX_HI : cbr_pkg::WR_BLK_MAX_LO;
      end
      return rf ? cbr_pkg::RD_BLK_MAX_RF : cbr_pkg::RD_BLK_MAX;
   endfunction : blk_max

   function automatic logic [8:0] data_len(input logic [7:0] m);
      return {m[4:0], 4'h0};
   endfunction : data_len

   logic wr_cmd;
   logic [8:0] rlen;
   logic [8:0] didx;
   logic [7:0] rbyte;
   logic svc_bad;
   logic blk_bad;
   logic pop;

   assign wr_cmd = (s_ff.code == cbr_pkg::CMD_WRITE);
   // Error answer trimmed
   // short error answer
   assign rlen = (s_ff.err || wr_cmd) ? cbr_pkg::RSP_BASE_LEN :
                 cbr_pkg::RSP_BASE_LEN + 9'h001 + data_len(s_ff.m);
   assign didx = s_ff.ridx - cbr_pkg::RSP_BASE_LEN - 9'h001;
   assign svc_bad = (s_ff.k < cbr_pkg::SVC_MIN) ||
                    (s_ff.k > (wr_cmd ? cbr_pkg::WR_SVC_MAX : cbr_pkg::RD_SVC_MAX));
   assign blk_bad = (s_ff.m < cbr_pkg::BLK_MIN) || (s_ff.m > blk_max(wr_cmd, s_ff.k, rf_mode));
   assign pop = link.rsp_valid && link.rsp_ready;

   always_comb
   begin
      rbyte = cbr_pkg::ST2_OK;
      if (s_ff.ridx == 9'h000)
      begin
         rbyte = wr_cmd ? cbr_pkg::RSP_WRITE : cbr_pkg::RSP_READ;
      end
      else if (s_ff.ridx < cbr_pkg::RSP_IDX_ST1)
      begin
         rbyte = cbr_pkg::id_byte(own_id, 4'(s_ff.ridx - 9'h001));
      end
      else if (s_ff.ridx == cbr_pkg::RSP_IDX_ST1)
      begin
         rbyte = s_ff.err ? cbr_pkg::ST1_ERR : cbr_pkg::ST1_OK;
      end
      else if (s_ff.ridx == cbr_pkg::RSP_IDX_ST2)
      begin
         rbyte = s_ff.st2;
      end
      else if (s_ff.ridx == cbr_pkg::RSP_IDX_M)
      begin
         rbyte = s_ff.m;
      end
      else if (tunnel_mode)
      begin
         rbyte = s_ff.dbuf[didx[7:0]];
      end
      else
      begin
         rbyte = s_ff.mem[{s_ff.blk[didx[7:4]][3:0], didx[3:0]}];
      end
   end

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.hreq = 1'b0;
      if (pop)
      begin
         nxt_s.frd = ~s_ff.frd;
         nxt_s.fcnt = nxt_s.fcnt - 2'd1;
      end
      case (s_ff.st)
         S_CMD:
         begin
            if (link.cmd_valid)
            begin
               case (s_ff.ph)
                  P_CODE:
                  begin
                     nxt_s.code = link.cmd_data;
                     nxt_s.id_ok = 1'b1;
                     nxt_s.svc_diff = 1'b0;
                     nxt_s.cnt = 9'h000;
                     nxt_s.ph = P_ID;
                  end
                  P_ID:
                  begin
                     if (link.cmd_data != cbr_pkg::id_byte(own_id, s_ff.cnt[3:0]))
                     begin
                        nxt_s.id_ok = 1'b0;
                     end
                     nxt_s.cnt = s_ff.cnt + 9'h001;
                     if (s_ff.cnt == 9'(cbr_pkg::ID_BYTES - 1))
                     begin
                        nxt_s.ph = P_K;
                     end
                  end
                  P_K:
                  begin
                     nxt_s.k = link.cmd_data;
                     nxt_s.cnt = 9'h000;
                     nxt_s.ph = (link.cmd_data == 8'h00) ? P_M : P_SVC;
                  end
                  P_SVC:
                  begin
                     if (s_ff.cnt < 9'h002)
                     begin
                        nxt_s.svc0[s_ff.cnt[0] ? 7 : 15 -: 8] = link.cmd_data;
                     end
                     else if (link.cmd_data != s_ff.svc0[s_ff.cnt[0] ? 7 : 15 -: 8])
                     begin
                        nxt_s.svc_diff = 1'b1;
                     end
                     nxt_s.cnt = s_ff.cnt + 9'h001;
                     if (s_ff.cnt == {s_ff.k, 1'b0} - 9'h001)
                     begin
                        nxt_s.ph = P_M;
                     end
                  end
                  P_M:
                  begin
                     nxt_s.m = link.cmd_data;
                     nxt_s.bi = 4'h0;
                     nxt_s.ebyte = 2'd0;
                     nxt_s.ph = (link.cmd_data == 8'h00 || link.cmd_data > cbr_pkg::RD_BLK_MAX) ? P_END : P_BL;
                  end
                  P_BL:
                  begin
                     if (s_ff.ebyte == 2'd0)
                     begin
                        nxt_s.elen = link.cmd_data[cbr_pkg::BL_SHORT_BIT] ? 2'd2 : 2'd3;
                     end
                     if (s_ff.ebyte == 2'd1)
                     begin
                        nxt_s.blk[s_ff.bi] = link.cmd_data;
                     end
                     nxt_s.ebyte = s_ff.ebyte + 2'd1;
                     if (s_ff.ebyte != 2'd0 && s_ff.ebyte == s_ff.elen - 2'd1)
                     begin
                        nxt_s.ebyte = 2'd0;
                        nxt_s.bi = s_ff.bi + 4'h1;
                        nxt_s.cnt = 9'h000;
                        if ({4'h0, s_ff.bi} == s_ff.m - 8'h01)
                        begin
                           nxt_s.ph = wr_cmd ? P_DATA : P_END;
                        end
                     end
                  end
                  P_DATA:
                  begin
                     nxt_s.dbuf[s_ff.cnt[7:0]] = link.cmd_data;
                     nxt_s.cnt = s_ff.cnt + 9'h001;
                     if (s_ff.cnt == data_len(s_ff.m) - 9'h001)
                     begin
                        nxt_s.ph = P_END;
                     end
                  end
                  default:
                  begin
                     nxt_s.ph = P_END;
                  end
               endcase
               if (link.cmd_last)
               begin
                  nxt_s.comp = (nxt_s.ph == P_END);
                  nxt_s.ph = P_CODE;
                  nxt_s.st = S_EVAL;
               end
            end
         end
         S_EVAL:
         begin
            nxt_s.ridx = 9'h000;
            nxt_s.bi = 4'h0;
            nxt_s.cnt = 9'h000;
            nxt_s.hidx = 8'h00;
            nxt_s.hdat = s_ff.dbuf[0];
            nxt_s.tmo = 16'h0000;
            nxt_s.err = 1'b1;
            nxt_s.st2 = cbr_pkg::ST2_OK;
            nxt_s.st = S_RSP;
            if (!s_ff.id_ok || (s_ff.code != cbr_pkg::CMD_READ && !wr_cmd) ||
                (!s_ff.comp && !svc_bad && !s_ff.svc_diff && !blk_bad))
            begin
               nxt_s.st = S_CMD;
            end
            else if (svc_bad)
            begin
               nxt_s.st2 = cbr_pkg::ST2_SVC_CNT;
            end
            else if (s_ff.svc_diff)
            begin
               nxt_s.st2 = cbr_pkg::ST2_SVC_DIFF;
            end
            else if (blk_bad)
            begin
               nxt_s.st2 = cbr_pkg::ST2_BLK_CNT;
            end
            else
            begin
               nxt_s.err = 1'b0;
               if (tunnel_mode)
               begin
                  nxt_s.st = wr_cmd ? S_TWR : S_TRD;
                  nxt_s.hreq = !wr_cmd;
               end
               else if (wr_cmd)
               begin
                  nxt_s.st = S_MWR;
               end
            end
         end
         S_MWR:
         begin
            nxt_s.mem[{s_ff.blk[s_ff.bi][3:0], s_ff.cnt[3:0]}] = s_ff.dbuf[{s_ff.bi, s_ff.cnt[3:0]}];
            nxt_s.cnt = s_ff.cnt + 9'h001;
            if (s_ff.cnt[3:0] == 4'hF)
            begin
               nxt_s.bi = s_ff.bi + 4'h1;
               if ({4'h0, s_ff.bi} == s_ff.m - 8'h01)
               begin
                  nxt_s.st = S_RSP;
               end
            end
         end
         S_TWR:
         begin
            if (host_wr_ready)
            begin
               nxt_s.hidx = s_ff.hidx + 8'h01;
               nxt_s.hdat = s_ff.dbuf[nxt_s.hidx];
               if (host_wr_last)
               begin
                  nxt_s.st = S_TWAIT;
               end
            end
         end
         S_TWAIT, S_TRD:
         begin
            nxt_s.tmo = s_ff.tmo + 16'h0001;
            if (s_ff.st == S_TRD && host_rd_valid)
            begin
               nxt_s.tmo = 16'h0000;
               nxt_s.dbuf[{s_ff.bi, s_ff.cnt[3:0]}] = host_rd_data;
               nxt_s.cnt = s_ff.cnt + 9'h001;
               if (s_ff.cnt[3:0] == 4'hF)
               begin
                  nxt_s.bi = s_ff.bi + 4'h1;
                  nxt_s.hreq = 1'b1;
                  if ({4'h0, s_ff.bi} == s_ff.m - 8'h01)
                  begin
                     nxt_s.hreq = 1'b0;
                     nxt_s.st = S_RSP;
                  end
               end
            end
            else if (s_ff.st == S_TWAIT && host_ack)
            begin
               nxt_s.st = S_RSP;
            end
            if (host_err)
            begin
               nxt_s.err = 1'b1;
               nxt_s.st2 = cbr_pkg::ST2_HOST_ERR;
               nxt_s.st = S_RSP;
            end
            else if (s_ff.tmo == 16'(HOST_WAIT - 1))
            begin
               nxt_s.err = 1'b1;
               nxt_s.st2 = cbr_pkg::ST2_HOST_SILENT;
               nxt_s.st = S_RSP;
            end
         end
         S_RSP:
         begin
            if (s_ff.fcnt != 2'd2 || pop)
            begin
               nxt_s.fifo[s_ff.fwr] = {s_ff.ridx == rlen - 9'h001, rbyte};
               nxt_s.fwr = ~s_ff.fwr;
               nxt_s.fcnt = nxt_s.fcnt + 2'd1;
               nxt_s.ridx = s_ff.ridx + 9'h001;
               if (s_ff.ridx == rlen - 9'h001)
               begin
                  nxt_s.st = S_CMD;
               end
            end
         end
         default:
         begin
            nxt_s.st = S_CMD;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign link.cmd_ready = (s_ff.st == S_CMD);
   assign link.rsp_valid = (s_ff.fcnt != 2'd0);
   assign link.rsp_data = s_ff.fifo[s_ff.frd][7:0];
   assign link.rsp_last = s_ff.fifo[s_ff.frd][8];
   assign host_rd_req = s_ff.hreq;
   assign host_blk = s_ff.blk[s_ff.bi];
   assign host_wr_valid = (s_ff.st == S_TWR);
   assign host_wr_data = s_ff.hdat;
   assign host_wr_last = (s_ff.st == S_TWR) && ({1'b0, s_ff.hidx} == data_len(s_ff.m) - 9'h001);
endmodule : cbr_tag
`default_nettype wire

// ===== logic/cbr_reader.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_reader #(
   parameter int RSP_WAIT = cbr_pkg::RSP_WAIT_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   cbr_link_if.reader link,
   input wire logic start,
   input wire logic op_write,
   input wire logic [63:0] card_id,
   input wire logic [7:0] svc_count,
   input wire logic [7:0] blk_count,
   input wire logic [7:0] blk_base,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   output logic busy,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic done,
   output logic timeout,
   output logic [7:0] rsp_code,
   output logic [7:0] status1,
   output logic [7:0] status2
);
   typedef enum logic [1:0] {R_IDLE, R_SEND, R_RECV} cbr_rst_t;
   typedef struct packed {
      cbr_rst_t st;
      logic wr;
      logic [63:0] id;
      logic [7:0] k;
      logic [7:0] m;
      logic [7:0] base;
      logic [8:0] idx;
      logic [16:0] tmo;
      logic [7:0] code;
      logic [7:0] s1;
      logic [7:0] s2;
      logic done;
      logic tout;
      logic rdv;
      logic [7:0] rdd;
   } cbr_rd_st_t;

   cbr_rd_st_t s_ff;
   cbr_rd_st_t nxt_s;
   logic [8:0] hdr_end;
   logic [8:0] bl_end;
   logic [8:0] total;
   logic [8:0] off;
   logic in_data;
   logic [7:0] cbyte;

   assign hdr_end = cbr_pkg::CMD_IDX_K + 9'h002 + {s_ff.k, 1'b0};
   assign bl_end = hdr_end + {s_ff.m, 1'b0};
   assign total = bl_end + (s_ff.wr ? {s_ff.m[4:0], 4'h0} : 9'h000);
   assign off = s_ff.idx - hdr_end;
   assign in_data = (s_ff.idx >= bl_end);

   always_comb
   begin
      cbyte = wr_data;
      if (s_ff.idx == 9'h000)
      begin
         cbyte = s_ff.wr ? cbr_pkg::CMD_WRITE : cbr_pkg::CMD_READ;
      end
      else if (s_ff.idx < cbr_pkg::CMD_IDX_K)
      begin
         cbyte = cbr_pkg::id_byte(s_ff.id, 4'(s_ff.idx - 9'h001));
      end
      else if (s_ff.idx == cbr_pkg::CMD_IDX_K)
      begin
         cbyte = s_ff.k;
      end
      else if (s_ff.idx < hdr_end - 9'h001)
      begin
         cbyte = s_ff.idx[0] ? cbr_pkg::SVC_FILL_LO : cbr_pkg::SVC_FILL_HI;
      end
      else if (s_ff.idx == hdr_end - 9'h001)
      begin
         cbyte = s_ff.m;
      end
      else if (!in_data)
      begin
         cbyte = off[0] ? s_ff.base + off[8:1] : cbr_pkg::BL_SHORT_HDR;
      end
   end

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.done = 1'b0;
      nxt_s.rdv = 1'b0;
      case (s_ff.st)
         R_IDLE:
         begin
            if (start)
            begin
               nxt_s.wr = op_write;
               nxt_s.id = card_id;
               nxt_s.k = svc_count;
               nxt_s.m = blk_count;
               nxt_s.base = blk_base;
               nxt_s.idx = 9'h000;
               nxt_s.tout = 1'b0;
               nxt_s.st = R_SEND;
            end
         end
         R_SEND:
         begin
            if (link.cmd_valid && link.cmd_ready)
            begin
               nxt_s.idx = s_ff.idx + 9'h001;
               if (link.cmd_last)
               begin
                  nxt_s.idx = 9'h000;
                  nxt_s.tmo = 17'h00000;
                  nxt_s.st = R_RECV;
               end
            end
         end
         R_RECV:
         begin
            nxt_s.tmo = s_ff.tmo + 17'h00001;
            if (link.rsp_valid)
            begin
               nxt_s.idx = s_ff.idx + 9'h001;
               if (s_ff.idx == 9'h000)
               begin
                  nxt_s.code = link.rsp_data;
               end
               else if (s_ff.idx == cbr_pkg::RSP_IDX_ST1)
               begin
                  nxt_s.s1 = link.rsp_data;
               end
               else if (s_ff.idx == cbr_pkg::RSP_IDX_ST2)
               begin
                  nxt_s.s2 = link.rsp_data;
               end
               else if (s_ff.idx > cbr_pkg::RSP_IDX_M)
               begin
                  nxt_s.rdv = 1'b1;
                  nxt_s.rdd = link.rsp_data;
               end
               if (link.rsp_last)
               begin
                  nxt_s.done = 1'b1;
                  nxt_s.st = R_IDLE;
               end
            end
            else if (s_ff.tmo == 17'(RSP_WAIT - 1))
            begin
               nxt_s.done = 1'b1;
               nxt_s.tout = 1'b1;
               nxt_s.st = R_IDLE;
            end
         end
         default:
         begin
            nxt_s.st = R_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_ff <= '0;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   assign link.cmd_valid = (s_ff.st == R_SEND) && (!in_data || wr_valid);
   assign link.cmd_data = cbyte;
   assign link.cmd_last = (s_ff.idx == total - 9'h001);
   assign link.rsp_ready = (s_ff.st == R_RECV);
   assign wr_ready = (s_ff.st == R_SEND) && in_data && link.cmd_ready;
   assign busy = (s_ff.st != R_IDLE);
   assign rd_valid = s_ff.rdv;
   assign rd_data = s_ff.rdd;
   assign done = s_ff.done;
   assign timeout = s_ff.tout;
   assign rsp_code = s_ff.code;
   assign status1 = s_ff.s1;
   assign status2 = s_ff.s2;
endmodule : cbr_reader
`default_nettype wire

// ===== tb/cbr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cbr_sva (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_last,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire logic [7:0] rsp_data,
   input wire logic rsp_last
);
   logic ctk;
   logic rtk;
   logic [8:0] ci_ff;
   logic [8:0] ri_ff;
   logic [7:0] code_ff;
   logic [7:0] k_ff;
   logic [7:0] m_ff;
   logic [7:0] s1_ff;
   assign ctk = cmd_valid && cmd_ready;
   assign rtk = rsp_valid && rsp_ready;
   // Byte positions and captured fields
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ci_ff <= 9'h000;
         ri_ff <= 9'h000;
         code_ff <= 8'h00;
         k_ff <= 8'h00;
         m_ff <= 8'h00;
         s1_ff <= 8'h00;
      end
      else
      begin
         if (ctk)
         begin
            ci_ff <= cmd_last ? 9'h000 : ci_ff + 9'h001;
            if (ci_ff == 9'h000) code_ff <= cmd_data;
            if (ci_ff == 9'h009) k_ff <= cmd_data;
            if (ci_ff == {k_ff, 1'b0} + 9'h00A) m_ff <= cmd_data;
         end
         if (rtk)
         begin
            ri_ff <= rsp_last ? 9'h000 : ri_ff + 9'h001;
            if (ri_ff == 9'h009) s1_ff <= rsp_data;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_eval;
      !cmd_ready;
   endsequence
   sequence s_busy;
      !cmd_ready || !rsp_valid;
   endsequence
   a_rdy_low: assert property (ctk && cmd_last |=> s_eval ##1 s_busy)
      else $error("command ready not dropped");
   a_rsp_code: assert property (rtk && ri_ff == 9'h000 |-> rsp_data == code_ff + 8'h01)
      else $error("wrong response code");
   a_stat_pair: assert property (rtk && ri_ff == 9'h00A |-> (s1_ff == 8'h00 && rsp_data == 8'h00) ||
      (s1_ff == 8'hFF && rsp_data != 8'h00))
      else $error("bad status pair");
   a_err_short: assert property (rtk && ri_ff == 9'h00A && s1_ff != 8'h00 |-> rsp_last)
      else $error("error answer too long");
   a_wr_short: assert property (rtk && ri_ff == 9'h00A && code_ff == 8'h08 |-> rsp_last)
      else $error("write answer too long");
   a_m_echo: assert property (rtk && ri_ff == 9'h00B |-> rsp_data == m_ff)
      else $error("block count not echoed");
   a_rd_len: assert property (rtk && rsp_last && code_ff == 8'h06 && s1_ff == 8'h00 |->
      {3'b000, ri_ff} == 12'h00B + {m_ff, 4'h0})
      else $error("read answer length");
   a_svc_cnt: assert property (rtk && ri_ff == 9'h00A && (k_ff == 8'h00 ||
      k_ff > (code_ff == 8'h06 ? 8'h0F : 8'h0B)) |-> rsp_data == 8'hA1)
      else $error("service count not refused");
   a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
      else $error("response byte dropped");
endmodule : cbr_sva
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // Arbitrary identifier value
   localparam logic [63:0] ID = 64'h0123456789ABCDEF;
   typedef struct packed {logic op; logic rf; logic [7:0] k; logic [7:0] m; logic [15:0] st;} cbr_row_t;
   cbr_row_t rows [13] = '{'{0,0,1,1,16'h0000}, '{0,0,15,15,16'h0000}, '{0,0,16,1,16'hFFA1},
      '{0,0,0,1,16'hFFA1}, '{0,1,1,14,16'hFFA2}, '{0,1,1,13,16'h0000}, '{0,0,1,16,16'hFFA2},
      '{0,0,1,0,16'hFFA2}, '{1,0,8,12,16'h0000}, '{1,0,8,13,16'hFFA2}, '{1,0,9,11,16'h0000},
      '{1,0,9,12,16'hFFA2}, '{1,0,12,1,16'hFFA1}};
   logic clk = 0, arst_n = 0, start = 0, op_write = 0, rf_mode = 0, tunnel_mode = 0, host_err = 0;
   logic [63:0] card_id = ID;
   logic [7:0] svc_count = 8'h01, blk_count = 8'h01, blk_base = 8'h00, wr_data = 8'h11;
   logic wr_ready, busy, rd_valid, done, timeout;
   logic [7:0] rd_data, rsp_code, status1, status2;
   logic host_on = 0, host_ack = 0, ack_d = 0, host_rd_valid = 0, host_rd_req, host_wr_valid, host_wr_last;
   logic [7:0] host_rd_data = 8'h00, host_blk, host_wr_data;
   logic [7:0] wq [$], rq [$], hq [$];
   int n_fail = 0, checked = 0, cyc = 0, h_cnt = 0;
   cbr_link_if link();
   cbr_tag #(.HOST_WAIT(50)) u_cbr_tag (.clk(clk), .arst_n(arst_n), .link(link.tag), .own_id(ID),
      .rf_mode(rf_mode), .tunnel_mode(tunnel_mode), .host_rd_req(host_rd_req), .host_blk(host_blk),
      .host_rd_valid(host_rd_valid), .host_rd_data(host_rd_data), .host_err(host_err), .host_ack(host_ack),
      .host_wr_valid(host_wr_valid), .host_wr_ready(1'b1), .host_wr_data(host_wr_data),
      .host_wr_last(host_wr_last));
   cbr_reader #(.RSP_WAIT(200)) u_cbr_reader (.clk(clk), .arst_n(arst_n), .link(link.reader),
      .start(start), .op_write(op_write), .card_id(card_id), .svc_count(svc_count),
      .blk_count(blk_count), .blk_base(blk_base), .wr_valid(1'b1), .wr_ready(wr_ready),
      .wr_data(wr_data), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
      .timeout(timeout), .rsp_code(rsp_code), .status1(status1), .status2(status2));
   cbr_sva u_cbr_sva (.clk(clk), .arst_n(arst_n), .cmd_valid(link.cmd_valid),
      .cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data), .cmd_last(link.cmd_last),
      .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data),
      .rsp_last(link.rsp_last));
   always #12.5 clk = ~clk;
   always @(negedge clk)
   begin
      if (wr_ready)
      begin
         wr_data = wr_data + 8'h07;
         wq.push_back(wr_data);
      end
      if (rd_valid) rq.push_back(rd_data);
      if (host_wr_valid) hq.push_back(host_wr_data);
      host_ack = ack_d && host_on;
      ack_d = host_wr_last;
      if (host_rd_req && host_on) h_cnt = 16;
      host_rd_valid = h_cnt > 0;
      if (host_rd_valid)
      begin
         host_rd_data = {host_blk[3:0], 4'(16 - h_cnt)};
         h_cnt--;
      end
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         summarize();
      end
   end
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task run(input logic w, input logic [7:0] k, input logic [7:0] m, input logic [7:0] b);
      int i;
      @(negedge clk);
      op_write = w;
      svc_count = k;
      blk_count = m;
      blk_base = b;
      start = 1;
      @(negedge clk);
      start = 0;
      for (i = 0; i < 2000 && done !== 1'b1; i++) @(negedge clk);
      chk("done", 1'b1, done);
      @(negedge clk);
   endtask : run
   task summarize;
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   initial
   begin
      repeat (20) @(negedge clk);
      chk("reset", 3'b001, {busy, link.rsp_valid, link.cmd_ready});
      arst_n = 1;
      foreach (rows[i])
      begin
         rf_mode = rows[i].rf;
         rq.delete();
         run(rows[i].op, rows[i].k, rows[i].m, 8'h00);
         chk("answer", {rows[i].op ? 8'h09 : 8'h07, rows[i].st}, {rsp_code, status1, status2});
         chk("bytes", (rows[i].op || rows[i].st != 0) ? 0 : 16 * rows[i].m, rq.size());
      end
      rf_mode = 0;
      start = 1;
      repeat (6) @(negedge clk);
      start = 0;
      arst_n = 0;
      @(negedge clk);
      chk("mid reset", 3'b001, {busy, link.rsp_valid, link.cmd_ready});
      arst_n = 1;
      wq.delete();
      run(1, 1, 2, 3);
      rq.delete();
      run(0, 1, 2, 3);
      chk("data count", 32, rq.size());
      for (int i = 0; i < 32; i++) chk("data", wq[i], rq[i]);
      card_id = ~ID;
      run(0, 1, 1, 0);
      chk("silent", 1, timeout);
      card_id = ID;
      tunnel_mode = 1;
      run(0, 1, 1, 0);
      chk("tunnel read", 16'hFF50, {status1, status2});
      host_err = 1;
      run(1, 1, 1, 0);
      chk("tunnel write", 16'hFF51, {status1, status2});
      host_err = 0;
      host_on = 1;
      hq.delete();
      wq.delete();
      run(1, 1, 2, 0);
      chk("host write", 24'h090000, {rsp_code, status1, status2});
      rq.delete();
      run(0, 1, 2, 5);
      chk("host read", 24'h070000, {rsp_code, status1, status2});
      chk("host count", 32, hq.size());
      chk("read count", 32, rq.size());
      for (int i = 0; i < 32; i++)
      begin
         chk("host wr data", wq[i], hq[i]);
         chk("host rd data", {4'(5 + i / 16), 4'(i)}, rq[i]);
      end
      summarize();
   end
endmodule : tb_top
`default_nettype wire
